//--- hw/ivs_map.vh
`ifndef IVS_MAP_VH
`define IVS_MAP_VH

// ****************************************************
// Register pointers and fields
// ****************************************************
`define IVS_PTR_CODE    8'h00
`define IVS_PTR_CTRL    8'h01
`define IVS_PAR_BIT     7
`define IVS_CODE_RST    7'h32
`define IVS_CTRL_INT    7
`define IVS_CTRL_MASK   4
`define IVS_CTRL_PWM    3
`define IVS_CTRL_LATCH  0
`define IVS_CTRL_RST    8'h09
`define IVS_CTRL_WMASK  8'h99

// ****************************************************
// Bus framing
// ****************************************************
`define IVS_BYTE_BITS   4'h8
`define IVS_SDA_DRIVE   1'b0

// ****************************************************
// Timing
// ****************************************************
`define IVS_CLK_NS      25
`define IVS_SPIKE_NS    32
`define IVS_SPIKE_CYC   ((`IVS_SPIKE_NS + `IVS_CLK_NS - 1) / `IVS_CLK_NS)
`define IVS_CHG_US      15
`define IVS_CHG_CYC     ((`IVS_CHG_US * 1000) / `IVS_CLK_NS)
`define IVS_OC_CYCLES   5'h10
`endif

//--- hw/ivs_pin_filter.v
`timescale 1ns/10ps
`default_nettype none
module ivs_pin_filter #(
   parameter integer         WIDTH    = 2,
   parameter integer         FILT_CYC = 2,
   parameter integer         CW       = 4,
   parameter [WIDTH-1:0]     RST_VAL  = {WIDTH{1'b1}}
) (
   // Clocking
   input  wire               clk,
   input  wire               rst,
   input  wire               ce,
   // Pins in, clean levels out
   input  wire [WIDTH-1:0]   din,
   output wire [WIDTH-1:0]   dout
);
   localparam [CW-1:0] LIM = FILT_CYC[CW-1:0];

   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         reg          s1_q;
         reg          s2_q;
         reg          f_q;
         reg [CW-1:0] c_q;
         always @(posedge clk) begin
            if (rst) begin
               s1_q <= RST_VAL[g];
               s2_q <= RST_VAL[g];
               f_q  <= RST_VAL[g];
               c_q  <= {CW{1'b0}};
            end else if (ce) begin
               s1_q <= din[g];
               s2_q <= s1_q;
               // New level must hold LIM+1 samples; shorter pulses are spikes
               if (s2_q == f_q) begin
                  c_q <= {CW{1'b0}};
               end else if (c_q == LIM) begin
                  f_q <= s2_q;
                  c_q <= {CW{1'b0}};
               end else begin
                  c_q <= c_q + 1'b1;
               end
            end
         end
         assign dout[g] = f_q;
      end
   endgenerate
endmodule // ivs_pin_filter
`default_nettype wire

//--- hw/ivs_i2c_slave.v
`timescale 1ns/10ps
`default_nettype none
`include "ivs_map.vh"
module ivs_i2c_slave #(
   parameter [6:0]   SLAVE_ADDR = 7'h20,
   parameter integer CHG_CYC    = `IVS_CHG_CYC
) (
   // Clocking
   input  wire       CLK,
   input  wire       RST,
   input  wire       CE,
   // Two-wire bus, data is open drain
   input  wire       SCL_IN,
   input  wire       SDA_IN,
   output wire       SDA_OUT,
   output wire       SDA_OE,
   // Power-stage status
   input  wire       OVERCURRENT,
   input  wire       SW_CYCLE,
   input  wire       ENABLE_IN,
   // Control levels to the regulator
   output wire [6:0] OUTPUT_VOLTAGE_CODE,
   output wire       INTERNAL_MODE,
   output wire       PROT_OFF_ON_CHANGE,
   output wire       LIGHT_LOAD_PWM_SELECT,
   output wire       LATCH_OFF_MODE,
   output wire       PROTECTION_SUSPEND,
   output wire       POWER_SWITCH_OFF
);
   // ****************************************************
   // States
   // ****************************************************
   localparam [9:0] S_IDLE  = 10'h001;
   localparam [9:0] S_ADDR  = 10'h002;
   localparam [9:0] S_AACK  = 10'h004;
   localparam [9:0] S_REG   = 10'h008;
   localparam [9:0] S_RACK  = 10'h010;
   localparam [9:0] S_WDAT  = 10'h020;
   localparam [9:0] S_WACK  = 10'h040;
   localparam [9:0] S_RDAT  = 10'h080;
   localparam [9:0] S_MACK  = 10'h100;
   localparam [9:0] S_SKIP  = 10'h200;
   localparam [11:0] CHG_LIM = CHG_CYC[11:0];

   // ****************************************************
   // Input conditioning
   // ****************************************************
   wire [1:0] bus_f;
   wire [2:0] ana_f;

   ivs_pin_filter #(
      .WIDTH    (2),
      .FILT_CYC (`IVS_SPIKE_CYC),
      .CW       (4),
      .RST_VAL  (2'h3)
   ) u_bus_filter (
      .clk  (CLK),
      .rst  (RST),
      .ce   (CE),
      .din  ({SCL_IN, SDA_IN}),
      .dout (bus_f)
   );

   // Analog levels are only synchronised; no spike window
   ivs_pin_filter #(
      .WIDTH    (3),
      .FILT_CYC (0),
      .CW       (4),
      .RST_VAL  (3'h0)
   ) u_ana_sync (
      .clk  (CLK),
      .rst  (RST),
      .ce   (CE),
      .din  ({OVERCURRENT, SW_CYCLE, ENABLE_IN}),
      .dout (ana_f)
   );

   wire scl = bus_f[1];
   wire sda = bus_f[0];
   wire oc  = ana_f[2];
   wire sw  = ana_f[1];
   wire en  = ana_f[0];

   reg  scl_p_q;
   reg  sda_p_q;
   reg  sw_p_q;

   wire scl_rise = scl & ~scl_p_q;
   wire scl_fall = ~scl & scl_p_q;
   wire start_c  = scl & scl_p_q & sda_p_q & ~sda;
   wire stop_c   = scl & scl_p_q & ~sda_p_q & sda;
   wire sw_rise  = sw & ~sw_p_q;

   // ****************************************************
   // Bus engine registers
   // ****************************************************
   reg [9:0] state_q;
   reg [3:0] cnt_q;
   reg [7:0] rx_q;
   reg [7:0] tx_q;
   reg       rw_q;
   reg       ptr_q;
   reg       oe_q;
   reg [7:0] code_q;
   reg [7:0] ctrl_q;
   reg       code_wr_q;

   // Odd parity over whole byte: bit 7 is XNOR of bits 6..0
   wire par_ok   = rx_q[`IVS_PAR_BIT] == ~^rx_q[6:0];
   wire addr_hit = rx_q[7:1] == SLAVE_ADDR;
   wire ptr_ok   = (rx_q == `IVS_PTR_CODE) | (rx_q == `IVS_PTR_CTRL);
   // Control byte carries no parity: its top bit is the mode select
   wire wr_ok    = ptr_q ? 1'b1 : par_ok;
   wire [7:0] rd_byte = ptr_q ? (ctrl_q & `IVS_CTRL_WMASK) : code_q;
   wire byte_done = cnt_q == `IVS_BYTE_BITS;

   always @(posedge CLK) begin
      if (RST) begin
         scl_p_q   <= 1'b1;
         sda_p_q   <= 1'b1;
         sw_p_q    <= 1'b0;
         state_q   <= S_IDLE;
         cnt_q     <= 4'h0;
         rx_q      <= 8'h00;
         tx_q      <= 8'h00;
         rw_q      <= 1'b0;
         ptr_q     <= 1'b0;
         oe_q      <= 1'b0;
         code_q    <= {~^`IVS_CODE_RST, `IVS_CODE_RST};
         ctrl_q    <= `IVS_CTRL_RST;
         code_wr_q <= 1'b0;
      end else if (CE) begin
         scl_p_q   <= scl;
         sda_p_q   <= sda;
         sw_p_q    <= sw;
         code_wr_q <= 1'b0;
         if (start_c) begin
            // Every START, repeated or not, restarts address matching
            state_q <= S_ADDR;
            cnt_q   <= 4'h0;
            oe_q    <= 1'b0;
         end else if (stop_c) begin
            state_q <= S_IDLE;
            oe_q    <= 1'b0;
         end else if (scl_rise) begin
            if ((state_q == S_ADDR) | (state_q == S_REG) | (state_q == S_WDAT)) begin
               rx_q  <= {rx_q[6:0], sda};
               cnt_q <= cnt_q + 4'h1;
            end else if (state_q == S_RDAT) begin
               cnt_q <= cnt_q + 4'h1;
            end
         end else if (scl_fall) begin
            case (state_q)
               S_ADDR: begin
                  if (byte_done) begin
                     if (addr_hit) begin
                        rw_q    <= rx_q[0];
                        oe_q    <= 1'b1;
                        state_q <= S_AACK;
                     end else begin
                        state_q <= S_SKIP;
                     end
                  end
               end
               S_AACK: begin
                  cnt_q <= 4'h0;
                  if (rw_q) begin
                     tx_q    <= {rd_byte[6:0], 1'b0};
                     oe_q    <= ~rd_byte[7];
                     state_q <= S_RDAT;
                  end else begin
                     oe_q    <= 1'b0;
                     state_q <= S_REG;
                  end
               end
               S_REG: begin
                  if (byte_done) begin
                     if (ptr_ok) begin
                        ptr_q   <= rx_q[0];
                        oe_q    <= 1'b1;
                        state_q <= S_RACK;
                     end else begin
                        state_q <= S_SKIP;
                     end
                  end
               end
               S_RACK: begin
                  oe_q    <= 1'b0;
                  cnt_q   <= 4'h0;
                  state_q <= S_WDAT;
               end
               S_WDAT: begin
                  if (byte_done) begin
                     if (wr_ok) begin
                        oe_q    <= 1'b1;
                        state_q <= S_WACK;
                        if (ptr_q) begin
                           ctrl_q <= rx_q & `IVS_CTRL_WMASK;
                        end else begin
                           code_q    <= rx_q;
                           code_wr_q <= 1'b1;
                        end
                     end else begin
                        state_q <= S_SKIP;
                     end
                  end
               end
               S_WACK: begin
                  // One data byte per write; later bytes are not taken
                  oe_q    <= 1'b0;
                  state_q <= S_SKIP;
               end
               S_RDAT: begin
                  if (byte_done) begin
                     oe_q    <= 1'b0;
                     state_q <= S_MACK;
                  end else begin
                     oe_q <= ~tx_q[7];
                     tx_q <= {tx_q[6:0], 1'b0};
                  end
               end
               S_MACK: begin
                  // Master answer is not checked; nothing is resent
                  state_q <= S_SKIP;
               end
               S_IDLE, S_SKIP: begin
                  oe_q <= 1'b0;
               end
               default: begin
                  oe_q    <= 1'b0;
                  state_q <= S_IDLE;
               end
            endcase
         end
      end
   end

   // ****************************************************
   // Code-change protection window
   // ****************************************************
   reg [11:0] chg_q;

   always @(posedge CLK) begin
      if (RST) begin
         chg_q <= 12'h000;
      end else if (CE) begin
         if (code_wr_q) begin
            chg_q <= CHG_LIM;
         end else if (chg_q != 12'h000) begin
            chg_q <= chg_q - 12'h001;
         end
      end
   end

   // ****************************************************
   // Overcurrent switch-off and protection suspend
   // ****************************************************
   reg [4:0] oc_cnt_q;
   reg       latch_q;
   reg       off_q;
   reg       susp_q;

   wire oc_fault = oc_cnt_q == `IVS_OC_CYCLES;

   always @(posedge CLK) begin
      if (RST) begin
         oc_cnt_q <= 5'h00;
         latch_q  <= 1'b0;
         off_q    <= 1'b0;
         susp_q   <= 1'b0;
      end else if (CE) begin
         // Held clear while disabled, so a fresh enable edge always restarts
         if (~oc | ~en) begin
            oc_cnt_q <= 5'h00;
         end else if (sw_rise & ~oc_fault) begin
            oc_cnt_q <= oc_cnt_q + 5'h01;
         end
         if (oc_fault & ctrl_q[`IVS_CTRL_LATCH]) begin
            latch_q <= 1'b1;
         end else if (~en) begin
            latch_q <= 1'b0;
         end
         off_q  <= latch_q | (oc_fault & ~ctrl_q[`IVS_CTRL_LATCH]);
         susp_q <= ctrl_q[`IVS_CTRL_MASK] & (code_wr_q | (chg_q != 12'h000));
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   assign SDA_OUT               = `IVS_SDA_DRIVE;
   assign SDA_OE                = oe_q;
   assign OUTPUT_VOLTAGE_CODE   = code_q[6:0];
   assign INTERNAL_MODE         = ctrl_q[`IVS_CTRL_INT];
   assign PROT_OFF_ON_CHANGE    = ctrl_q[`IVS_CTRL_MASK];
   assign LIGHT_LOAD_PWM_SELECT = ctrl_q[`IVS_CTRL_PWM];
   assign LATCH_OFF_MODE        = ctrl_q[`IVS_CTRL_LATCH];
   assign PROTECTION_SUSPEND    = susp_q;
   assign POWER_SWITCH_OFF      = off_q;
endmodule // ivs_i2c_slave
`default_nettype wire

//--- verification/ivs_i2c_slave_properties.sv
`timescale 1ns/10ps
`default_nettype none
module ivs_i2c_slave_chk #(
   parameter integer CHG_CYC = 600
) (
   // Clocking
   input wire logic       CLK,
   input wire logic       RST,
   // Bus and power stage
   input wire logic       SDA_OUT,
   input wire logic       SDA_OE,
   input wire logic       OVERCURRENT,
   input wire logic       ENABLE_IN,
   // Control levels
   input wire logic [6:0] OUTPUT_VOLTAGE_CODE,
   input wire logic       INTERNAL_MODE,
   input wire logic       PROT_OFF_ON_CHANGE,
   input wire logic       LIGHT_LOAD_PWM_SELECT,
   input wire logic       LATCH_OFF_MODE,
   input wire logic       PROTECTION_SUSPEND,
   input wire logic       POWER_SWITCH_OFF
);
   // ****************************************
   // Helper: length of the suspend window
   // ****************************************
   logic [15:0] sus_cnt_q;
   wire  [15:0] sus_cnt_d = PROTECTION_SUSPEND ? sus_cnt_q + 16'h0001 : 16'h0000;
   always @(posedge CLK) begin
      sus_cnt_q <= RST ? 16'h0000 : sus_cnt_d;
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   property p_rst_vals;
      $fell(RST) |-> OUTPUT_VOLTAGE_CODE == 7'h32 && !INTERNAL_MODE && !PROT_OFF_ON_CHANGE
         && LIGHT_LOAD_PWM_SELECT && LATCH_OFF_MODE && !SDA_OE && !POWER_SWITCH_OFF;
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
   property p_sda_low;
      SDA_OE |-> SDA_OUT == 1'b0;
   endproperty
   a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
   property p_code_on_ack;
      $changed(OUTPUT_VOLTAGE_CODE) |-> $rose(SDA_OE);
   endproperty
   a_code_on_ack: assert property (p_code_on_ack) else $error("code changed without ack");
   property p_ctrl_on_ack;
      $changed({INTERNAL_MODE, PROT_OFF_ON_CHANGE, LIGHT_LOAD_PWM_SELECT, LATCH_OFF_MODE})
         |-> $rose(SDA_OE);
   endproperty
   a_ctrl_on_ack: assert property (p_ctrl_on_ack) else $error("control changed without ack");
   property p_susp_cause;
      $rose(PROTECTION_SUSPEND) |-> $past(PROT_OFF_ON_CHANGE) && $past(SDA_OE);
   endproperty
   a_susp_cause: assert property (p_susp_cause) else $error("suspend without cause");
   property p_susp_len;
      $fell(PROTECTION_SUSPEND) |-> sus_cnt_q == CHG_CYC + 1;
   endproperty
   a_susp_len: assert property (p_susp_len) else $error("suspend window length wrong");
   property p_read_release;
      $rose(SDA_OE) |-> ##[1:100] !SDA_OE;
   endproperty
   a_read_release: assert property (p_read_release) else $error("data pin held too long");
   property p_off_cause;
      $rose(POWER_SWITCH_OFF) |-> $past(OVERCURRENT, 10) && $past(ENABLE_IN, 10);
   endproperty
   a_off_cause: assert property (p_off_cause) else $error("switch off without fault");
   property p_latch_hold;
      $fell(POWER_SWITCH_OFF) && LATCH_OFF_MODE |-> !$past(ENABLE_IN, 2);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch left without enable");
endmodule // ivs_i2c_slave_chk
bind ivs_i2c_slave ivs_i2c_slave_chk #(.CHG_CYC(CHG_CYC)) chk (.CLK(CLK), .RST(RST),
   .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .OVERCURRENT(OVERCURRENT), .ENABLE_IN(ENABLE_IN),
   .OUTPUT_VOLTAGE_CODE(OUTPUT_VOLTAGE_CODE), .INTERNAL_MODE(INTERNAL_MODE),
   .PROT_OFF_ON_CHANGE(PROT_OFF_ON_CHANGE), .LIGHT_LOAD_PWM_SELECT(LIGHT_LOAD_PWM_SELECT),
   .LATCH_OFF_MODE(LATCH_OFF_MODE), .PROTECTION_SUSPEND(PROTECTION_SUSPEND),
   .POWER_SWITCH_OFF(POWER_SWITCH_OFF));
`default_nettype wire

//--- verification/ivs_bus_master.sv
`timescale 1ns/10ps
`default_nettype none
module ivs_bus_master #(
   parameter logic [6:0] ADDR = 7'h2C
) (
   // Clock and bus
   input  wire logic clk,
   input  wire logic sda,
   output var  logic scl,
   output var  logic sda_m
);
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // Pins move on falling CLK edges; a bus bit is eleven of them
   // Clock stays low for seven, so a slave answer lands before the rise
   task automatic q(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_m = b;
      q(5);
      scl = 1'b1;
      q(4);
      r = sda;
      scl = 1'b0;
      q(2);
   endtask
   // Long lead-in lets a slave ack drop before clock rises, avoiding a false stop
   task automatic start;
      sda_m = 1'b1;
      q(8);
      scl = 1'b1;
      q(4);
      sda_m = 1'b0;
      q(4);
      scl = 1'b0;
      q(2);
   endtask
   task automatic stop;
      sda_m = 1'b0;
      q(2);
      scl = 1'b1;
      q(4);
      sda_m = 1'b1;
      q(8);
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(1'b1, a);
      ack = ~a;
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
                     output logic [2:0] ack);
      logic [7:0] junk;
      start;
      xfer({dev, 1'b0}, junk, ack[2]);
      xfer(ptr, junk, ack[1]);
      xfer(d, junk, ack[0]);
      stop;
   endtask
   task automatic rd(input logic [7:0] ptr, output logic [7:0] d, output logic [2:0] ack);
      logic [7:0] junk;
      start;
      xfer({ADDR, 1'b0}, junk, ack[2]);
      xfer(ptr, junk, ack[1]);
      start;
      xfer({ADDR, 1'b1}, junk, ack[0]);
      xfer(8'hFF, d, junk[0]);
      stop;
   endtask
endmodule // ivs_bus_master
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
module tb_top;
   localparam logic [6:0] DEV = 7'h2C;
   logic clk;
   logic rst = 1'b1;
   logic oc = 1'b0;
   logic sw = 1'b0;
   logic en = 1'b1;
   logic seen = 1'b0;
   logic scl, sda_m, sda_out, sda_oe, int_mode, prot, pwm, latch, susp, off;
   logic [6:0] code;
   logic [7:0] cv [3] = '{8'hFF, 8'h66, 8'h11};
   int err_total = 0;
   int num_checks = 0;
   wire sda = sda_m & (sda_oe ? sda_out : 1'b1);
   wire [3:0] ctrl_lv = {int_mode, prot, pwm, latch};
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   ivs_i2c_slave #(.SLAVE_ADDR(DEV), .CHG_CYC(8)) dut (.CLK(clk), .RST(rst), .CE(1'b1),
      .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .OVERCURRENT(oc),
      .SW_CYCLE(sw), .ENABLE_IN(en), .OUTPUT_VOLTAGE_CODE(code), .INTERNAL_MODE(int_mode),
      .PROT_OFF_ON_CHANGE(prot), .LIGHT_LOAD_PWM_SELECT(pwm), .LATCH_OFF_MODE(latch),
      .PROTECTION_SUSPEND(susp), .POWER_SWITCH_OFF(off));
   ivs_bus_master #(.ADDR(DEV)) m (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
   always @(posedge clk) begin
      if (susp === 1'b1) seen <= 1'b1;
   end
   function automatic logic [7:0] par(input logic [6:0] c);
      return {~^c, c};
   endfunction
   task automatic sw_pulse;
      sw = 1'b1;
      repeat (3) @(negedge clk);
      sw = 1'b0;
      repeat (3) @(negedge clk);
   endtask
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #1_000_000;
      err_total++;
      print_verdict;
   end
   initial begin
      logic [2:0] a;
      logic [7:0] d;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      repeat (8) @(negedge clk);
      `CHK("code_rst", 7'h32, code)
      `CHK("ctrl_rst", 4'b0011, ctrl_lv)
      m.rd(8'h00, d, a);
      `CHK("rd00_rst", 8'h32, d)
      `CHK("rd_ack", 3'b111, a)
      m.rd(8'h01, d, a);
      `CHK("rd01_rst", 8'h09, d)
      m.wr(DEV, 8'h00, par(7'h55), a);
      `CHK("wr_ack", 3'b111, a)
      `CHK("code_wr", 7'h55, code)
      m.wr(DEV, 8'h00, par(7'h0F) ^ 8'h80, a);
      `CHK("par_ack", 3'b110, a)
      `CHK("par_code", 7'h55, code)
      m.wr(DEV ^ 7'h01, 8'h00, par(7'h0F), a);
      `CHK("dev_ack", 3'b000, a)
      m.wr(DEV, 8'h02, par(7'h0F), a);
      `CHK("ptr_ack", 3'b100, a)
      `CHK("code_kept", 7'h55, code)
      m.wr(DEV, 8'h00, par(7'h0F), a);
      m.rd(8'h00, d, a);
      `CHK("rd00", par(7'h0F), d)
      `CHK("susp_none", 1'b0, seen)
      foreach (cv[i]) begin
         m.wr(DEV, 8'h01, cv[i], a);
         `CHK("ctrl_ack", 3'b111, a)
         `CHK("ctrl_out", {cv[i][7], cv[i][4], cv[i][3], cv[i][0]}, ctrl_lv)
         m.rd(8'h01, d, a);
         `CHK("ctrl_rd", cv[i] & 8'h99, d)
      end
      m.wr(DEV, 8'h00, par(7'h40), a);
      `CHK("susp_seen", 1'b1, seen)
      oc = 1'b1;
      repeat (15) sw_pulse;
      repeat (8) @(negedge clk);
      `CHK("off_15", 1'b0, off)
      sw_pulse;
      repeat (8) @(negedge clk);
      `CHK("off_16", 1'b1, off)
      oc = 1'b0;
      repeat (8) @(negedge clk);
      `CHK("latched", 1'b1, off)
      en = 1'b0;
      repeat (8) @(negedge clk);
      `CHK("en_clear", 1'b0, off)
      en = 1'b1;
      m.wr(DEV, 8'h01, 8'h08, a);
      oc = 1'b1;
      repeat (16) sw_pulse;
      repeat (8) @(negedge clk);
      `CHK("auto_off", 1'b1, off)
      oc = 1'b0;
      repeat (8) @(negedge clk);
      `CHK("auto_back", 1'b0, off)
      print_verdict;
   end
endmodule // tb_top
`default_nettype wire
